// [verilog/ptf_pkg.sv]
// Shared constants and carriers for the position feedback and teach block.
// Assumes a 100 MHz system clock and a stroke sensor on that clock.
package ptf_pkg;

  // Clock and time base.
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned MS_CYC = CLK_KHZ * TICK_MS;

  // Hold and blink times, counted in millisecond ticks.
  localparam logic [11:0] HOLD_TEACH_MS = 12'h5dc;
  localparam logic [11:0] HOLD_COMBO_MS = 12'h9c4;
  localparam logic [11:0] HOLD_SELECT_MS = 12'h1f4;
  localparam logic [8:0] FAST_HALF_MS = 9'h064;
  localparam logic [8:0] SLOW_HALF_MS = 9'h1f4;
  localparam logic [2:0] FLASH_PHASES = 3'h6;

  // Stroke in hundredths of a millimetre, measurable from 0 to 85 mm.
  localparam int unsigned STROKE_W = 14;
  localparam int unsigned SPAN_MM = 85;
  localparam int unsigned RES_PER_MM = 100;
  localparam logic [13:0] STROKE_MAX = 14'(SPAN_MM * RES_PER_MM);
  localparam logic [13:0] TOL_RESET = 14'h0064;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TOL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_POS1 = 8'h0c;
  localparam logic [7:0] ADDR_POS2 = 8'h10;
  localparam logic [7:0] ADDR_POS3 = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
  localparam logic [7:0] ADDR_STROKE = 8'h20;

  // Control register command bits, all self-clearing.
  localparam int unsigned CTRL_TEACH_LSB = 0;
  localparam int unsigned CTRL_CLEAR = 3;
  localparam int unsigned CTRL_AT_ENTER = 4;
  localparam int unsigned CTRL_AT_FAIL = 5;
  localparam int unsigned CTRL_AT_DONE = 6;

  // Interrupt event bits.
  localparam int unsigned IRQ_W = 5;
  localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

  // Indicator colour codes.
  localparam logic [2:0] COL_NONE = 3'h0;
  localparam logic [2:0] COL_POS1 = 3'h1;
  localparam logic [2:0] COL_POS2 = 3'h2;
  localparam logic [2:0] COL_POS3 = 3'h3;
  localparam logic [2:0] COL_ERR = 3'h4;
  localparam logic [2:0] COL_ALL = 3'h7;

  typedef struct packed {
    logic valid;
    logic [13:0] mm;
  } ptf_stroke_t;

  typedef struct packed {
    logic on;
    logic [2:0] color;
  } ptf_led_t;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_SELECT = 3'b010,
    MODE_RUN = 3'b100
  } ptf_mode_t;

  typedef enum logic [1:0] {
    IND_LIVE = 2'b01,
    IND_FLASH = 2'b10
  } ptf_ind_t;

endpackage

// [verilog/ptf_hold_timer.sv]
// Hold timer for one button pattern, counting millisecond ticks.
// Assumes en_i comes from synchronised buttons on the same clock.
`timescale 1ns/1ps

module ptf_hold_timer #(
  parameter logic [11:0] LIMIT_MS = 12'h001
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Time base and condition
  input wire logic tick_i,
  input wire logic en_i,
  // One-cycle pulse when the hold is complete
  output logic fire_o
);

  logic [11:0] cnt_q;

  assign fire_o = en_i && tick_i && (cnt_q == LIMIT_MS - 12'h001);

  // Restart on release; saturate so one hold fires only once.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      cnt_q <= 12'h000;
    else if (!en_i)
      cnt_q <= 12'h000; // [RULE_17]
    else if (tick_i && cnt_q != LIMIT_MS)
      cnt_q <= cnt_q + 12'h001;
  end

  a_hold_full: assert property (@(posedge clk_i) // [RULE_17]
    disable iff (!resetn_i)
    fire_o |-> $past(en_i) && cnt_q == LIMIT_MS - 12'h001)
    else $error("Hold fired without a full hold.");

endmodule

// [verilog/ptf_top.sv]
// Position feedback and teach logic for a valve control head.
// Assumes the stroke sample is on clk_i and the pins are asynchronous.
// How it works
// [RULE_01] Button one held 1.5 s stores stroke as position one, three flashes.
// [RULE_02] Button two held 1.5 s stores stroke as position two, three flashes.
// [RULE_03] Button three held 1.5 s stores position three, then slow blink.
// [RULE_04] Buttons one and two held 2.5 s clear all positions, error blink.
// [RULE_05] Stroke is valid only from zero to 85 mm.
// [RULE_06] Three position outputs, each high while stroke matches its position.
// [RULE_07] Initiator input is passed to the initiator output.
// [RULE_08] A match means stroke within a configurable tolerance of position.
// [RULE_09] Teaching out of range gives an error-colour blink.
// [RULE_10] Out of range, all outputs low and indicator dark; only the position outputs drop, the initiator still passes.
// [RULE_11] Any button may capture any stroke, no ordering between positions.
// [RULE_12] Indicator stays lit while the target sits at a taught position; at position three it blinks slowly.
// [RULE_13] Buttons and software teach requests give the same result.
// [RULE_14] Six automatic teach procedures can be selected.
// [RULE_15] Buttons two and three held 2.5 s enter automatic selection.
// [RULE_16] A failed automatic run clears every position.
// [RULE_17] Hold counters restart on release; early release fires nothing.
// [RULE_18] A two-button hold suppresses both single-button actions.
`timescale 1ns/1ps

module ptf_top #(
  parameter int unsigned MS_CYC = ptf_pkg::MS_CYC
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Teach button and initiator pins
  input wire logic teach_button_one_i,
  input wire logic teach_button_two_i,
  input wire logic teach_button_three_i,
  input wire logic initiator_input_i,
  // Stroke sensor
  input wire ptf_pkg::ptf_stroke_t stroke_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // Feedback outputs
  output logic position_one_output_o,
  output logic position_two_output_o,
  output logic position_three_output_o,
  output logic initiator_output_o,
  output ptf_pkg::ptf_led_t indicator_o,
  output logic irq_o,
  // Automatic teach sequencer
  output logic autotune_run_o,
  output logic [2:0] autotune_sel_o
);

  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [2:0] btn;
  logic [2:0] btn_prev_q;
  logic [16:0] ms_cnt_q;
  logic ms_tick;
  logic in_range;
  logic normal;
  logic fire1, fire2, fire3, fire12, fire23, fire_sel;
  logic armed_q;
  logic wr_ctrl;
  logic [2:0] teach_req;
  logic clear_req;
  logic at_enter;
  logic at_fail;
  logic at_done;
  logic teach_ok;
  logic teach_err;
  logic sel_ok;
  logic [2:0][13:0] pos_q;
  logic [2:0] taught_q;
  logic [2:0] match;
  logic [2:0] pos_out_q;
  logic init_out_q;
  logic [13:0] tol_q;
  ptf_pkg::ptf_mode_t mode_q;
  logic [2:0] sel_q;
  ptf_pkg::ptf_ind_t ind_q;
  logic [2:0] flash_col_q;
  logic [2:0] flash_cnt_q;
  logic [8:0] fast_cnt_q;
  logic [8:0] slow_cnt_q;
  logic fast_ph_q;
  logic slow_ph_q;
  logic fast_flip;
  ptf_pkg::ptf_led_t led_d;
  ptf_pkg::ptf_led_t led_q;
  logic [4:0] irq_ev;
  logic [4:0] irq_stat_q;
  logic [4:0] irq_mask_q;
  logic [31:0] rdata_q;

  // Every property below runs on the system clock and sleeps in reset.
  default clocking cb_chk @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Two flip-flops on every pin before any logic looks at it.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
    end
    else
    begin
      pin_s1_q <= {initiator_input_i, teach_button_three_i,
                   teach_button_two_i, teach_button_one_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign btn = pin_s2_q[2:0];

  // Millisecond enable; all slower timing runs from this pulse.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || ms_tick)
      ms_cnt_q <= 17'h00000;
    else
      ms_cnt_q <= ms_cnt_q + 17'h00001;
  end

  assign ms_tick = (ms_cnt_q == 17'(MS_CYC - 1));

  // Sensor sample outside the span counts as no target.
  assign in_range = stroke_i.valid &&
                    (stroke_i.mm <= ptf_pkg::STROKE_MAX); // [RULE_05]
  assign normal = (mode_q == ptf_pkg::MODE_NORMAL);

  // Exact patterns only, so a pair never also runs a single action.
  ptf_hold_timer #(.LIMIT_MS(ptf_pkg::HOLD_TEACH_MS)) u_hold1 (
    .clk_i(clk_i), .resetn_i(resetn_i), .tick_i(ms_tick),
    .en_i(normal && btn == 3'h1), .fire_o(fire1)); // [RULE_18]
  ptf_hold_timer #(.LIMIT_MS(ptf_pkg::HOLD_TEACH_MS)) u_hold2 (
    .clk_i(clk_i), .resetn_i(resetn_i), .tick_i(ms_tick),
    .en_i(normal && btn == 3'h2), .fire_o(fire2)); // [RULE_18]
  ptf_hold_timer #(.LIMIT_MS(ptf_pkg::HOLD_TEACH_MS)) u_hold3 (
    .clk_i(clk_i), .resetn_i(resetn_i), .tick_i(ms_tick),
    .en_i(normal && btn == 3'h4), .fire_o(fire3));
  ptf_hold_timer #(.LIMIT_MS(ptf_pkg::HOLD_COMBO_MS)) u_hold12 (
    .clk_i(clk_i), .resetn_i(resetn_i), .tick_i(ms_tick),
    .en_i(normal && btn == 3'h3), .fire_o(fire12)); // [RULE_04]
  ptf_hold_timer #(.LIMIT_MS(ptf_pkg::HOLD_COMBO_MS)) u_hold23 (
    .clk_i(clk_i), .resetn_i(resetn_i), .tick_i(ms_tick),
    .en_i(normal && btn == 3'h6), .fire_o(fire23)); // [RULE_15]
  ptf_hold_timer #(.LIMIT_MS(ptf_pkg::HOLD_SELECT_MS)) u_hold_sel (
    .clk_i(clk_i), .resetn_i(resetn_i), .tick_i(ms_tick),
    .en_i(mode_q == ptf_pkg::MODE_SELECT && armed_q && btn != 3'h0 &&
          btn == btn_prev_q),
    .fire_o(fire_sel));

  // Software commands share the button paths from here on.
  assign wr_ctrl = reg_we_i && reg_addr_i == ptf_pkg::ADDR_CTRL;
  assign teach_req = {fire3, fire2, fire1} |
    ((wr_ctrl && mode_q != ptf_pkg::MODE_SELECT) ?
     reg_wdata_i[ptf_pkg::CTRL_TEACH_LSB +: 3] : 3'h0); // [RULE_13]
  assign clear_req = fire12 ||
    (wr_ctrl && reg_wdata_i[ptf_pkg::CTRL_CLEAR]); // [RULE_13]
  assign at_enter = fire23 ||
    (normal && wr_ctrl && reg_wdata_i[ptf_pkg::CTRL_AT_ENTER]);
  assign at_fail = !normal && wr_ctrl &&
    reg_wdata_i[ptf_pkg::CTRL_AT_FAIL];
  assign at_done = mode_q == ptf_pkg::MODE_RUN && wr_ctrl &&
    reg_wdata_i[ptf_pkg::CTRL_AT_DONE];
  assign teach_ok = (|teach_req) && in_range;
  assign teach_err = (|teach_req) && !in_range; // [RULE_09]

  // Six selections from the six button patterns; seven is no choice.
  function automatic logic [2:0] at_code(input logic [2:0] b);
    case (b)
      3'h1: at_code = 3'h1;
      3'h2: at_code = 3'h2;
      3'h4: at_code = 3'h3;
      3'h3: at_code = 3'h4;
      3'h5: at_code = 3'h5;
      3'h6: at_code = 3'h6;
      default: at_code = 3'h0;
    endcase
  endfunction

  assign sel_ok = fire_sel && at_code(btn_prev_q) != 3'h0;

  // Positions store with no order check; a clear or a failed run wins.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pos_q <= '0;
      taught_q <= 3'h0;
    end
    else if (clear_req || at_fail)
      taught_q <= 3'h0; // [RULE_04] [RULE_16]
    else if (in_range)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (teach_req[i])
        begin
          pos_q[i] <= stroke_i.mm; // [RULE_01] [RULE_02] [RULE_03] [RULE_11]
          taught_q[i] <= 1'b1;
        end
      end
    end
  end

  // Window compare against each taught position.
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (stroke_i.mm >= pos_q[i])
        match[i] = taught_q[i] && (stroke_i.mm - pos_q[i] <= tol_q);
      else
        match[i] = taught_q[i] && (pos_q[i] - stroke_i.mm <= tol_q);
    end
  end

  // Registered feedback; no position output reports while the target is lost, the initiator still passes.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pos_out_q <= 3'h0;
      init_out_q <= 1'b0;
    end
    else
    begin
      pos_out_q <= in_range ? match : 3'h0; // [RULE_06] [RULE_08] [RULE_10]
      init_out_q <= pin_s2_q[3]; // [RULE_07]
    end
  end

  // Automatic teach mode. Buttons must be let go once after entry, or the
  // entry hold itself would pick procedure six.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      mode_q <= ptf_pkg::MODE_NORMAL;
      sel_q <= 3'h0;
      armed_q <= 1'b0;
      btn_prev_q <= 3'h0;
    end
    else
    begin
      btn_prev_q <= btn;
      unique case (mode_q)
        ptf_pkg::MODE_NORMAL:
        begin
          armed_q <= 1'b0;
          if (at_enter)
            mode_q <= ptf_pkg::MODE_SELECT; // [RULE_15]
        end
        ptf_pkg::MODE_SELECT:
        begin
          if (btn == 3'h0)
            armed_q <= 1'b1;
          if (at_fail)
            mode_q <= ptf_pkg::MODE_NORMAL;
          else if (sel_ok)
          begin
            mode_q <= ptf_pkg::MODE_RUN;
            sel_q <= at_code(btn_prev_q); // [RULE_14]
          end
        end
        ptf_pkg::MODE_RUN:
        begin
          if (at_fail || at_done)
            mode_q <= ptf_pkg::MODE_NORMAL; // [RULE_16]
        end
      endcase
    end
  end

  // Blink dividers; the fast one restarts so a flash begins lit.
  assign fast_flip = ms_tick && fast_cnt_q == ptf_pkg::FAST_HALF_MS - 9'h001;
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || teach_ok || teach_err)
    begin
      fast_cnt_q <= 9'h000;
      fast_ph_q <= 1'b1;
    end
    else if (fast_flip)
    begin
      fast_cnt_q <= 9'h000;
      fast_ph_q <= !fast_ph_q;
    end
    else if (ms_tick)
      fast_cnt_q <= fast_cnt_q + 9'h001;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      slow_cnt_q <= 9'h000;
      slow_ph_q <= 1'b0;
    end
    else if (ms_tick && slow_cnt_q == ptf_pkg::SLOW_HALF_MS - 9'h001)
    begin
      slow_cnt_q <= 9'h000;
      slow_ph_q <= !slow_ph_q;
    end
    else if (ms_tick)
      slow_cnt_q <= slow_cnt_q + 9'h001;
  end

  // Indicator sequencer: three quick flashes, then the live pattern.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      ind_q <= ptf_pkg::IND_LIVE;
      flash_col_q <= ptf_pkg::COL_NONE;
      flash_cnt_q <= 3'h0;
    end
    else if (teach_ok || teach_err)
    begin
      ind_q <= ptf_pkg::IND_FLASH;
      flash_cnt_q <= 3'h0;
      if (teach_err)
        flash_col_q <= ptf_pkg::COL_ERR; // [RULE_09]
      else if (teach_req[2])
        flash_col_q <= ptf_pkg::COL_POS3;
      else if (teach_req[1])
        flash_col_q <= ptf_pkg::COL_POS2;
      else
        flash_col_q <= ptf_pkg::COL_POS1;
    end
    else if (clear_req || at_fail)
      ind_q <= ptf_pkg::IND_LIVE;
    else if (ind_q == ptf_pkg::IND_FLASH && fast_flip)
    begin
      flash_cnt_q <= flash_cnt_q + 3'h1;
      if (flash_cnt_q == ptf_pkg::FLASH_PHASES - 3'h1)
        ind_q <= ptf_pkg::IND_LIVE;
    end
  end

  // Live pattern: untaught blinks in the error colour, position three
  // blinks slowly, positions one and two stay lit while matched.
  always_comb
  begin
    led_d.on = 1'b0;
    led_d.color = ptf_pkg::COL_NONE;
    if (ind_q == ptf_pkg::IND_FLASH)
    begin
      led_d.on = fast_ph_q;
      led_d.color = flash_col_q;
    end
    else if (!normal)
    begin
      led_d.on = 1'b1;
      led_d.color = ptf_pkg::COL_ALL;
    end
    else if (!in_range)
      led_d.on = 1'b0; // [RULE_10]
    else if (taught_q == 3'h0)
    begin
      led_d.on = slow_ph_q; // [RULE_04]
      led_d.color = ptf_pkg::COL_ERR;
    end
    else if (match[0])
    begin
      led_d.on = 1'b1; // [RULE_01] [RULE_12]
      led_d.color = ptf_pkg::COL_POS1;
    end
    else if (match[1])
    begin
      led_d.on = 1'b1; // [RULE_02] [RULE_12]
      led_d.color = ptf_pkg::COL_POS2;
    end
    else if (match[2])
    begin
      led_d.on = slow_ph_q; // [RULE_03]
      led_d.color = ptf_pkg::COL_POS3;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      led_q <= '0;
    else
      led_q <= led_d;
  end

  // Sticky events; a new event in the clearing read cycle is kept.
  assign irq_ev = {at_fail, sel_ok, clear_req, teach_err, teach_ok};
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      irq_stat_q <= 5'h00;
    else if (reg_re_i && reg_addr_i == ptf_pkg::ADDR_IRQ_STAT)
      irq_stat_q <= irq_ev;
    else
      irq_stat_q <= irq_stat_q | irq_ev;
  end

  // Writable settings.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      tol_q <= ptf_pkg::TOL_RESET;
      irq_mask_q <= ptf_pkg::IRQ_MASK_RESET;
    end
    else if (reg_we_i)
    begin
      if (reg_addr_i == ptf_pkg::ADDR_TOL)
        tol_q <= reg_wdata_i[13:0]; // [RULE_08]
      if (reg_addr_i == ptf_pkg::ADDR_IRQ_MASK)
        irq_mask_q <= reg_wdata_i[4:0];
    end
  end

  // Read data stand for one cycle only; unmapped reads give zero.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || !reg_re_i)
      rdata_q <= 32'h0000_0000;
    else
      case (reg_addr_i)
        ptf_pkg::ADDR_TOL: rdata_q <= {18'h00000, tol_q};
        ptf_pkg::ADDR_STATUS: rdata_q <= {18'h00000, sel_q, mode_q,
          init_out_q, pos_out_q, in_range, taught_q};
        ptf_pkg::ADDR_POS1: rdata_q <= {18'h00000, pos_q[0]};
        ptf_pkg::ADDR_POS2: rdata_q <= {18'h00000, pos_q[1]};
        ptf_pkg::ADDR_POS3: rdata_q <= {18'h00000, pos_q[2]};
        ptf_pkg::ADDR_IRQ_STAT: rdata_q <= {27'h0000000, irq_stat_q};
        ptf_pkg::ADDR_IRQ_MASK: rdata_q <= {27'h0000000, irq_mask_q};
        ptf_pkg::ADDR_STROKE: rdata_q <= {17'h00000, stroke_i};
        default: rdata_q <= 32'h0000_0000;
      endcase
  end

  assign reg_rdata_o = rdata_q;
  assign position_one_output_o = pos_out_q[0];
  assign position_two_output_o = pos_out_q[1];
  assign position_three_output_o = pos_out_q[2];
  assign initiator_output_o = init_out_q;
  assign indicator_o = led_q;
  assign irq_o = |(irq_stat_q & irq_mask_q);
  assign autotune_run_o = (mode_q == ptf_pkg::MODE_RUN);
  assign autotune_sel_o = sel_q;

  a_store_taught: assert property (teach_req[0] && in_range // [RULE_01]
    && !clear_req && !at_fail
    |=> pos_q[0] == $past(stroke_i.mm) && taught_q[0])
    else $error("Position one not stored.");

  a_store_three: assert property (teach_req[2] && in_range // [RULE_03]
    && !clear_req && !at_fail
    |=> pos_q[2] == $past(stroke_i.mm) ##1 ind_q == ptf_pkg::IND_FLASH)
    else $error("Position three not stored or not flashed.");

  a_clear_all: assert property (clear_req |=> taught_q == 3'h0) // [RULE_04]
    else $error("Clear left a position taught.");

  a_range_dark: assert property (!in_range && normal // [RULE_10]
    && ind_q == ptf_pkg::IND_LIVE |=> pos_out_q == 3'h0 && !led_q.on)
    else $error("Feedback shown with target out of range.");

  a_window_match: assert property (pos_out_q[1] // [RULE_08]
    |-> $past(in_range && taught_q[1]) &&
    ($past(stroke_i.mm) - $past(pos_q[1]) <= $past(tol_q) ||
     $past(pos_q[1]) - $past(stroke_i.mm) <= $past(tol_q)))
    else $error("Position two reported outside its window.");

  a_initiator_pass: assert property ($rose(initiator_input_i) // [RULE_07]
    ##1 initiator_input_i [*3] |-> initiator_output_o)
    else $error("Initiator level not passed through.");

  a_teach_error: assert property (teach_err // [RULE_09]
    |=> ind_q == ptf_pkg::IND_FLASH && flash_col_q == ptf_pkg::COL_ERR
    && $stable(taught_q))
    else $error("Out of range teach not flagged.");

  a_pair_only: assert property (btn == 3'h3 |-> !fire1 && !fire2) // [RULE_18]
    else $error("Single action fired during a pair hold.");

  a_at_fail: assert property (at_fail // [RULE_16]
    |=> taught_q == 3'h0 && mode_q == ptf_pkg::MODE_NORMAL)
    else $error("Failed run kept positions or mode.");

  a_steady_lit: assert property (normal && in_range && match[0] // [RULE_12]
    && ind_q == ptf_pkg::IND_LIVE
    |=> led_q.on && led_q.color == ptf_pkg::COL_POS1)
    else $error("Position one indicator not steady.");

endmodule

// [sim/ptf_sensor_model.sv]
// Stroke sensor and external initiator model feeding the teach block.
// Assumes the bench sets the target stroke and range on the same clock.
`timescale 1ns/1ps

module ptf_sensor_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Target set by the bench
  input wire logic in_range_i,
  input wire logic [13:0] mm_i,
  input wire logic init_i,
  // Sensor and initiator pins
  output ptf_pkg::ptf_stroke_t stroke_o,
  output logic initiator_o
);
  // Outside the span the sample is flagged invalid and its value churns,
  // so the block cannot lean on a stale reading.
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      stroke_o <= '0;
    else if (in_range_i)
      stroke_o <= {1'b1, mm_i};
    else
      stroke_o <= {1'b0, ~stroke_o.mm};
  end

  // The initiator is a plain switch contact.
  always_ff @(posedge clk_i)
  begin
    initiator_o <= init_i;
  end
endmodule

// [sim/position_teach_feedback_tb.sv]
// Self-checking bench for the position feedback and teach block.
// Assumes the millisecond tick is shortened to ten clock cycles.
`timescale 1ns/1ps

module position_teach_feedback_tb;
  localparam int MS = 10;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [2:0] btn = 3'h0;
  logic rng = 1'b1;
  logic [13:0] mm = 14'h0000;
  logic init = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [31:0] rdata, v;
  logic po1, po2, po3, io, irq, run;
  logic [2:0] sel;
  ptf_pkg::ptf_stroke_t stroke;
  ptf_pkg::ptf_led_t led;
  logic sens_init;
  int errors = 0;
  int num_checks = 0;

  always #5 clk_i = ~clk_i;

  ptf_sensor_model u_sens (.clk_i(clk_i), .resetn_i(resetn_i),
    .in_range_i(rng), .mm_i(mm), .init_i(init), .stroke_o(stroke),
    .initiator_o(sens_init));

  ptf_top #(.MS_CYC(MS)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .teach_button_one_i(btn[0]), .teach_button_two_i(btn[1]),
    .teach_button_three_i(btn[2]), .initiator_input_i(sens_init),
    .stroke_i(stroke), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
    .position_one_output_o(po1), .position_two_output_o(po2),
    .position_three_output_o(po3), .initiator_output_o(io),
    .indicator_o(led), .irq_o(irq), .autotune_run_o(run),
    .autotune_sel_o(sel));

  // One comparison, counted, reported on mismatch.
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Register write: one strobe cycle beside address and data.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    we <= 1'b0;
  endtask

  // Register read: the data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    re <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    re <= 1'b0;
    #1 d = rdata;
  endtask

  // Hold a button pattern for a number of milliseconds, then release.
  task automatic hold(input logic [2:0] b, input int ms);
    @(posedge clk_i);
    btn <= b;
    repeat (ms * MS) @(posedge clk_i);
    btn <= 3'h0;
    repeat (40) @(posedge clk_i);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Watchdog: the sequence needs roughly 90 thousand cycles.
  initial
  begin
    repeat (98000) @(posedge clk_i);
    errors++;
    complete_run();
  end

  initial
  begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(ptf_pkg::ADDR_TOL, v);
    check("tol", v, 32'h64);
    rd(ptf_pkg::ADDR_IRQ_MASK, v);
    check("mask", v, 32'h0);
    rd(8'hfc, v);
    check("unmapped", v, 32'h0);
    @(posedge clk_i);
    init <= 1'b1;
    wait_cyc(8);
    check("init on", io, 1'b1);
    init <= 1'b0;
    wait_cyc(8);
    check("init off", io, 1'b0);
    wr(ptf_pkg::ADDR_IRQ_MASK, 32'h1f);
    mm <= 14'd1000;
    wait_cyc(4);
    wr(ptf_pkg::ADDR_CTRL, 32'h1);
    wait_cyc(4);
    check("po1", po1, 1'b1);
    rd(ptf_pkg::ADDR_POS1, v);
    check("pos1", v, 32'd1000);
    check("irq on", irq, 1'b1);
    rd(ptf_pkg::ADDR_IRQ_STAT, v);
    check("irq stat", v, 32'h1);
    wait_cyc(2);
    check("irq off", irq, 1'b0);
    mm <= 14'd1050;
    wait_cyc(4);
    check("po1 near", po1, 1'b1);
    mm <= 14'd1200;
    wait_cyc(4);
    check("po1 far", po1, 1'b0);
    mm <= 14'd1000;
    wait_cyc(6100);
    check("led1", led, {1'b1, ptf_pkg::COL_POS1});
    mm <= 14'd500;
    hold(3'b010, 1520);
    rd(ptf_pkg::ADDR_POS2, v);
    check("pos2", v, 32'd500);
    check("po2", po2, 1'b1);
    wait_cyc(6100);
    check("led2", led, {1'b1, ptf_pkg::COL_POS2});
    hold(3'b100, 1000);
    rd(ptf_pkg::ADDR_STATUS, v);
    check("early", v[2], 1'b0);
    mm <= 14'd3000;
    hold(3'b100, 1520);
    rd(ptf_pkg::ADDR_POS3, v);
    check("pos3", v, 32'd3000);
    check("po3", po3, 1'b1);
    rng <= 1'b0;
    rd(ptf_pkg::ADDR_IRQ_STAT, v);
    wait_cyc(4);
    rd(ptf_pkg::ADDR_STATUS, v);
    check("outs off", v[6:4], 3'h0);
    wr(ptf_pkg::ADDR_CTRL, 32'h1);
    wait_cyc(4);
    check("err led", led, {1'b1, ptf_pkg::COL_ERR});
    rd(ptf_pkg::ADDR_POS1, v);
    check("pos1 kept", v, 32'd1000);
    rd(ptf_pkg::ADDR_IRQ_STAT, v);
    check("teach err", v, 32'h2);
    wait_cyc(6100);
    check("dark", led.on, 1'b0);
    rng <= 1'b1;
    hold(3'b011, 2520);
    rd(ptf_pkg::ADDR_STATUS, v);
    check("cleared", v[2:0], 3'h0);
    check("po3 off", po3, 1'b0);
    rd(ptf_pkg::ADDR_IRQ_STAT, v);
    check("pair only", v, 32'h4);
    wr(ptf_pkg::ADDR_CTRL, 32'h10);
    wait_cyc(3);
    check("select led", led, {1'b1, ptf_pkg::COL_ALL});
    hold(3'b001, 520);
    check("at run", run, 1'b1);
    check("at sel", sel, 3'h1);
    wr(ptf_pkg::ADDR_CTRL, 32'h1);
    rd(ptf_pkg::ADDR_STATUS, v);
    check("run teach", v[0], 1'b1);
    wr(ptf_pkg::ADDR_CTRL, 32'h20);
    rd(ptf_pkg::ADDR_STATUS, v);
    check("at clear", v[2:0], 3'h0);
    check("at mode", v[10:8], 3'h1);
    check("run off", run, 1'b0);
    rd(ptf_pkg::ADDR_IRQ_STAT, v);
    check("at irq", v, 32'h19);
    complete_run();
  end
endmodule
